// ===== hdl/usmsel_pkg.sv
// package of constants for the ulpi serial mode select block
package usmsel_pkg;
  // bit positions inside the interface control byte
  localparam int unsigned USMSEL_BIT_SIX = 0;
  localparam int unsigned USMSEL_BIT_THREE = 1;
  localparam int unsigned USMSEL_BIT_RSVD = 2;
  localparam int unsigned USMSEL_BIT_CLKON = 3;
  localparam int unsigned USMSEL_FIELD_W = 4;
  // reset values of the select and keep-on bits
  localparam logic USMSEL_RST_SEL = 1'b0;
  localparam logic USMSEL_RST_CLKON = 1'b0;
  localparam logic USMSEL_RSVD_VAL = 1'b0;
  localparam logic USMSEL_RST_RUN = 1'b1; // interface clock runs out of reset
  // data path widths of the modes
  localparam int unsigned USMSEL_THREE_W = 3;
  localparam int unsigned USMSEL_SIX_W = 6;
  // link mode encoding
  typedef enum logic [1:0] {
    USMSEL_MODE_PAR = 2'b00,
    USMSEL_MODE_THREE = 2'b01,
    USMSEL_MODE_SIX = 2'b10
  } usmsel_mode_t;
endpackage

// ===== hdl/usmsel_bit.sv
// one self-clearing serial select bit
`timescale 1ns/100ps
`default_nettype none
module usmsel_bit (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic wdata_i,
  input wire logic exit_i,
  output logic sel_o
);
  import usmsel_pkg::*;
  logic sel_reg;
  // write sets or clears; exit clears only when no write arrives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_reg <= USMSEL_RST_SEL;
    end else if (wr_i) begin
      sel_reg <= wdata_i;
    end else if (exit_i) begin
      sel_reg <= 1'b0;
    end
  end
  assign sel_o = sel_reg;
endmodule
`default_nettype wire

// ===== hdl/usmsel_top.sv
// serial mode select and serial clock control for the ulpi link
`timescale 1ns/100ps
`default_nettype none
// How it works
// - three-wire bit set, six-wire clear, selects 3-bit serial
// - select bits reset zero; zero means parallel
// - three-wire bit clears itself on exit
// - six-wire bit set selects 6-bit serial
// - six-wire bit clears itself on exit
// - keep-on bit resets zero; one keeps clock
// - keep-on only obeyed while suspend line high
// - keep-on only matters in serial modes
module usmsel_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ctrl_wr_i,
  input wire logic [usmsel_pkg::USMSEL_FIELD_W-1:0] ctrl_wdata_i,
  input wire logic serial_exit_i,
  input wire logic phy_active_low_suspend_i,
  output logic [usmsel_pkg::USMSEL_FIELD_W-1:0] ctrl_rdata_o,
  output logic three_wire_fsls_select_o,
  output logic six_wire_fsls_select_o,
  output usmsel_pkg::usmsel_mode_t link_mode_o,
  output logic [usmsel_pkg::USMSEL_SIX_W-1:0] serial_lane_en_o,
  output logic clock_run_o
);
  import usmsel_pkg::*;

  // the two select bits and the keep-on bit mirror the control byte that the
  // link controller writes; the mode, the lane enables and the clock enable
  // are registered once more so that the link pins never see a decode glitch
  // a serial exit clears both select bits at once, since only one serial mode
  // can be live at a time; a write in the same cycle as an exit wins, so the
  // controller never loses a write that it has just made
  // the reserved position is never stored, so it cannot read back as one

  logic three_sel; // three-wire select bit
  logic six_sel; // six-wire select bit
  logic clkon_reg; // serial clock keep-on bit
  usmsel_mode_t mode_next; // decoded link mode
  logic clk_next; // next interface clock enable
  logic [USMSEL_SIX_W-1:0] lane_next; // next serial lane enable

  // three-wire select bit, loaded by writes and dropped on a serial exit
  // three-wire auto clear
  usmsel_bit u_three (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(ctrl_wr_i),
    .wdata_i(ctrl_wdata_i[USMSEL_BIT_THREE]),
    .exit_i(serial_exit_i),
    .sel_o(three_sel)
  );

  // six-wire select bit, same clear rule as the three-wire bit
  // six-wire auto clear
  usmsel_bit u_six (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(ctrl_wr_i),
    .wdata_i(ctrl_wdata_i[USMSEL_BIT_SIX]),
    .exit_i(serial_exit_i),
    .sel_o(six_sel)
  );

  // keep-on bit: only a write changes it; a serial exit leaves it alone so
  // that the next serial session starts with the same clock policy
  // keep-on bit store
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clkon_reg <= USMSEL_RST_CLKON;
    end else if (ctrl_wr_i) begin
      clkon_reg <= ctrl_wdata_i[USMSEL_BIT_CLKON];
    end
  end

  // mode decode from the select bits; a controller that sets both bits at
  // once gets the wider six-wire path rather than a mix of lane sets
  // mode decode; six-wire wins if both set
  always_comb begin
    if (six_sel) begin
      // six-wire serial: all six lanes carry the packet
      mode_next = USMSEL_MODE_SIX;
      lane_next = {USMSEL_SIX_W{1'b1}};
    end else if (three_sel) begin
      // three-wire serial: the low three lanes only
      mode_next = USMSEL_MODE_THREE;
      lane_next = USMSEL_SIX_W'({USMSEL_THREE_W{1'b1}});
    end else begin
      // parallel: no serial lane is driven
      mode_next = USMSEL_MODE_PAR;
      lane_next = '0;
    end
  end

  // the clock may only stop in a serial mode; the keep-on bit is obeyed
  // only while the suspend line is high, and with the line low the bit
  // is ignored and the serial clock stays off
  // clock run decision
  always_comb begin
    if (mode_next == USMSEL_MODE_PAR) begin
      // parallel: the interface clock always runs
      clk_next = 1'b1;
    end else if (phy_active_low_suspend_i) begin
      // serial and awake: the keep-on bit decides
      clk_next = clkon_reg;
    end else begin
      // serial while suspended: keep-on ignored, clock off
      clk_next = 1'b0;
    end
  end

  // out of reset the link is parallel with the clock running, so the
  // controller can reach the register set before choosing a serial mode;
  // the outputs lag the stored bits by one cycle
  // registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_mode_o <= USMSEL_MODE_PAR;
      serial_lane_en_o <= '0;
      clock_run_o <= USMSEL_RST_RUN;
    end else begin
      link_mode_o <= mode_next;
      serial_lane_en_o <= lane_next;
      clock_run_o <= clk_next;
    end
  end

  // select bits are shown as stored, for the pins and for the read path
  assign three_wire_fsls_select_o = three_sel;
  assign six_wire_fsls_select_o = six_sel;

  // read path is a plain mux of stored bits with the reserved bit tied low
  // reserved reads zero
  always_comb begin
    ctrl_rdata_o = '0;
    ctrl_rdata_o[USMSEL_BIT_SIX] = six_sel;
    ctrl_rdata_o[USMSEL_BIT_THREE] = three_sel;
    ctrl_rdata_o[USMSEL_BIT_RSVD] = USMSEL_RSVD_VAL;
    ctrl_rdata_o[USMSEL_BIT_CLKON] = clkon_reg;
  end

  // checks on bits, mode, lanes and clock, next to the logic above
  // three-wire mode entry
  three_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (three_sel && !six_sel) |=> link_mode_o == USMSEL_MODE_THREE)
    else $error("three-wire mode not entered");

  par_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!three_sel && !six_sel) |=> (link_mode_o == USMSEL_MODE_PAR && serial_lane_en_o == '0))
    else $error("parallel mode not kept");

  three_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (serial_exit_i && !ctrl_wr_i) |=> !three_sel)
    else $error("three-wire bit not cleared on exit");

  six_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
    six_sel |=> (link_mode_o == USMSEL_MODE_SIX && serial_lane_en_o == {USMSEL_SIX_W{1'b1}}))
    else $error("six-wire mode not entered");

  six_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (serial_exit_i && !ctrl_wr_i) |=> !six_sel)
    else $error("six-wire bit not cleared on exit");

  keep_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_wr_i |=> clkon_reg == $past(ctrl_wdata_i[USMSEL_BIT_CLKON]))
    else $error("keep-on bit not stored");

  susp_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ((three_sel || six_sel) && !phy_active_low_suspend_i) |=> !clock_run_o)
    else $error("keep-on obeyed while suspended");

  par_clock_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!three_sel && !six_sel) |=> clock_run_o)
    else $error("clock stopped in parallel mode");

  rsvd_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_rdata_o[USMSEL_BIT_RSVD] == 1'b0)
    else $error("reserved bit not zero");

  three_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_wr_i |=> three_sel == $past(ctrl_wdata_i[USMSEL_BIT_THREE]))
    else $error("three-wire bit not written");

  three_lanes_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (three_sel && !six_sel) |=> serial_lane_en_o == USMSEL_SIX_W'({USMSEL_THREE_W{1'b1}}))
    else $error("three-wire lanes wrong");

  sel_reset_a: assert property (@(posedge clk_i)
    rst_i |=> (!three_sel && !six_sel && link_mode_o == USMSEL_MODE_PAR
      && serial_lane_en_o == '0))
    else $error("select bits not reset");

  six_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_wr_i |=> six_sel == $past(ctrl_wdata_i[USMSEL_BIT_SIX]))
    else $error("six-wire bit not written");

  keep_reset_a: assert property (@(posedge clk_i)
    rst_i |=> (clkon_reg == USMSEL_RST_CLKON && clock_run_o == USMSEL_RST_RUN))
    else $error("keep-on bit not reset");

  keep_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ((three_sel || six_sel) && !clkon_reg) |=> !clock_run_o)
    else $error("serial clock runs with keep-on clear");

  keep_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ((three_sel || six_sel) && phy_active_low_suspend_i) |=> clock_run_o == $past(clkon_reg))
    else $error("keep-on not obeyed while awake");
endmodule
`default_nettype wire

// ===== test/usmsel_link.sv
// link controller model driving the control byte
`timescale 1ns/100ps
`default_nettype none
module usmsel_link (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic [3:0] data_i,
  input wire logic exit_i,
  output logic ctrl_wr_o,
  output logic [3:0] ctrl_wdata_o,
  output logic serial_exit_o
);
  always_ff @(posedge clk_i) begin
    ctrl_wr_o <= req_i;
    ctrl_wdata_o <= data_i & 4'hB;
    serial_exit_o <= exit_i & ~req_i;
  end
endmodule
`default_nettype wire

// ===== test/usmsel_top_tb_top.sv
// self-checking bench for the serial mode select block
`timescale 1ns/100ps
`default_nettype none
module usmsel_top_tb_top;
  import usmsel_pkg::*;
  logic clk_i = 0, rst_i = 1, req = 0, ext = 0, susp = 0, wr, ex, three, six, crun;
  logic [3:0] d = 0, wd, rd, m;
  logic [3:0] exp_q[$];
  logic [5:0] lanes;
  logic [31:0] v;
  usmsel_mode_t mode;
  int n_fail = 0, checks_done = 0, seed = 32'h390e, i;
  bit s6, s3, ck;
  always #10 clk_i = ~clk_i;
  usmsel_link u_usmsel_link (.clk_i(clk_i), .req_i(req), .data_i(d), .exit_i(ext),
    .ctrl_wr_o(wr), .ctrl_wdata_o(wd), .serial_exit_o(ex));
  usmsel_top u_usmsel_top (.clk_i(clk_i), .rst_i(rst_i), .ctrl_wr_i(wr),
    .ctrl_wdata_i(wd), .serial_exit_i(ex), .phy_active_low_suspend_i(susp),
    .ctrl_rdata_o(rd), .three_wire_fsls_select_o(three), .six_wire_fsls_select_o(six),
    .link_mode_o(mode), .serial_lane_en_o(lanes), .clock_run_o(crun));
  // compare one value and count it
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // let the write land, then compare every output with the model
  task automatic wait_chk;
    repeat (4) @(posedge clk_i);
    #1;
    m = exp_q.pop_front();
    s6 = m[USMSEL_BIT_SIX];
    s3 = m[USMSEL_BIT_THREE];
    ck = m[USMSEL_BIT_CLKON];
    chk("rdata", rd, {ck, 1'b0, s3, s6});
    chk("three", three, s3);
    chk("six", six, s6);
    chk("mode", mode, s6 ? 8'h02 : (s3 ? 8'h01 : 8'h00));
    chk("lanes", lanes, s6 ? 8'h3F : (s3 ? 8'h07 : 8'h00));
    chk("clock", crun, !(s6 || s3) || (ck && susp));
  endtask
  // print counts and verdict, then end
  task automatic stop_test;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // one control write through the link model, with a new suspend level
  task automatic send(input logic [3:0] w, input logic s);
    @(posedge clk_i);
    d <= w;
    susp <= s;
    req <= 1;
    exp_q.push_back(w);
    @(posedge clk_i);
    req <= 0;
    wait_chk;
  endtask
  // one serial exit pulse; the model drops both selects and keeps keep-on
  task automatic leave;
    @(posedge clk_i);
    ext <= 1;
    exp_q.push_back({ck, 3'b000});
    @(posedge clk_i);
    ext <= 0;
    wait_chk;
  endtask
  // reset, random writes and exits, then a second reset in mid-run
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    exp_q.push_back(4'h0);
    wait_chk;
    for (i = 0; i < 60; i++) begin
      v = $random(seed);
      send(v[3:0], v[5]);
      if (v[4]) begin
        leave;
      end
    end
    // six-wire with keep-on, then a reset must clear it all
    send(4'h9, 1'b1);
    @(posedge clk_i);
    rst_i <= 1;
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    exp_q.push_back(4'h0);
    wait_chk;
    send(4'hA, 1'b1);
    leave;
    stop_test;
  end
endmodule
`default_nettype wire
